// >>> hw/spi_port_map.svh
// Register map, field positions, reset values and counts of the serial port.
// Assumes inclusion by bare name from the design files.
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
// ======================================================
// Register offsets
`define OFS_BUFFER 8'h00
`define OFS_CONTROL 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ 8'h0C
`define OFS_PINS 8'h10
// ======================================================
// Field positions
`define CTL_WRITE_COLLISION 7
`define CTL_OVF 6
`define CTL_EN 5
`define CTL_CKP 4
`define STA_SMP 7
`define STA_CKE 6
`define STA_BF 0
`define IRQ_FLAG 0
`define IRQ_EN 1
`define PIN_SDO_DIR 0
`define PIN_SCK_DIR 1
`define PIN_SS_DIR 2
`define PIN_SS_LATCH 3
// ======================================================
// Reset values
`define MODE_RESET 4'h0
`define PINS_RESET 4'hF
`define SYNC_RESET 3'h4
// ======================================================
// Counts
`define LAST_SAMPLE 4'h7
`define LAST_EDGE 5'h0F
`define HALF_DIV4 6'h01
`define HALF_DIV16 6'h07
`define HALF_DIV64 6'h1F
// ======================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hw/spi_port_pkg.sv
// Types shared by the serial port modules.
// Assumes nothing of its surroundings.
package spi_port_pkg;
  typedef enum logic [3:0] {
    MODE_MASTER_DIV4 = 4'b0000,
    MODE_MASTER_DIV16 = 4'b0001,
    MODE_MASTER_DIV64 = 4'b0010,
    MODE_MASTER_TIMER = 4'b0011,
    MODE_SLAVE_SS = 4'b0100,
    MODE_SLAVE_FREE = 4'b0101
  } port_mode_t;
  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } engine_state_t;
endpackage

// >>> hw/engine_if.sv
// Link between the register side of the serial port and its shift engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface engine_if;
  logic clear;
  logic load;
  logic [7:0] load_data;
  logic tick;
  logic master;
  logic cke;
  logic sample_phase;
  logic clock_polarity;
  logic serial_in;
  logic busy;
  logic done;
  logic [7:0] rx_data;
  logic tx_bit;
  logic sck_lvl;
  modport ctrl (output clear, load, load_data, tick, master, cke, sample_phase, clock_polarity, serial_in,
                input busy, done, rx_data, tx_bit, sck_lvl);
  modport eng (input clear, load, load_data, tick, master, cke, sample_phase, clock_polarity, serial_in,
               output busy, done, rx_data, tx_bit, sck_lvl);
endinterface

// >>> hw/serial_engine.sv
// Byte shift engine: counts clock edges, shifts out and samples in, MSB first.
// Assumes one tick per serial clock edge, supplied by the register side.
`timescale 1ns/100ps
`include "spi_port_map.svh"
module serial_engine (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  engine_if.eng bus
);
  spi_port_pkg::engine_state_t state_q;
  logic [4:0] edge_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic sck_q;
  logic done_q;
  logic run_tick;
  logic mid_pt;
  logic shift_pt;
  logic sample_pt;
  logic last;
  logic [1:0] samp_dly_q;
  logic [1:0] done_dly_q;
  logic samp_now;

  // ======================================================
  // Edge roles
  // Edge parity picks output or sample edge from the edge-select bit.
  assign mid_pt = edge_q[0] != bus.cke;
  assign shift_pt = (edge_q[0] == bus.cke) && (edge_q != 5'h00);
  assign sample_pt = bus.sample_phase ? shift_pt : mid_pt;
  assign last = sample_pt && (cnt_q == `LAST_SAMPLE);
  assign run_tick = bus.tick && ((state_q == spi_port_pkg::ENG_RUN) || !bus.master);

  // ======================================================
  // Sequence
  always_ff @(posedge aclk) begin
    if (!aresetn || bus.clear) begin
      state_q <= spi_port_pkg::ENG_IDLE;
      edge_q <= 5'h00;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (bus.load) begin
        state_q <= bus.master ? spi_port_pkg::ENG_RUN : spi_port_pkg::ENG_IDLE;
        edge_q <= 5'h00;
        cnt_q <= 4'h0;
      end else if (run_tick) begin
        if (last) begin
          state_q <= spi_port_pkg::ENG_IDLE;
          edge_q <= 5'h00;
          cnt_q <= 4'h0;
          done_q <= 1'b1;
        end else begin
          state_q <= spi_port_pkg::ENG_RUN;
          edge_q <= edge_q + 5'h01;
          if (sample_pt) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  end

  // ======================================================
  // Master sample delay
  // A master sample waits two cycles, one for each flop of the input synchroniser.
  // The byte end waits with it, so the buffer never takes a byte that still lacks its last bit.
  always_ff @(posedge aclk) begin
    if (!aresetn || bus.clear) begin
      samp_dly_q <= 2'h0;
      done_dly_q <= 2'h0;
    end else begin
      samp_dly_q <= {samp_dly_q[0], run_tick && sample_pt && bus.master};
      done_dly_q <= {done_dly_q[0], done_q && bus.master};
    end
  end
  assign samp_now = bus.master ? samp_dly_q[1] : (run_tick && sample_pt);

  // ======================================================
  // Data paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= 8'h00;
    end else if (bus.load) begin
      tx_q <= bus.load_data;
    end else if (run_tick && shift_pt) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q <= 8'h00;
    end else if (samp_now) begin
      rx_q <= {rx_q[6:0], bus.serial_in};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b0;
    end else if (state_q == spi_port_pkg::ENG_IDLE) begin
      sck_q <= bus.clock_polarity;
    end else if (run_tick && bus.master && (edge_q <= `LAST_EDGE)) begin
      sck_q <= ~sck_q;
    end
  end

  assign bus.busy = state_q == spi_port_pkg::ENG_RUN;
  assign bus.done = bus.master ? done_dly_q[1] : done_q;
  assign bus.rx_data = rx_q;
  assign bus.tx_bit = tx_q[7];
  assign bus.sck_lvl = sck_q;

  // ======================================================
  // Checks
  chk_sck_idle_level:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(state_q) == spi_port_pkg::ENG_IDLE) && (state_q == spi_port_pkg::ENG_IDLE) && $stable(bus.clock_polarity)
    |-> sck_q == bus.clock_polarity)
    else $error("Serial clock not at idle level.");
  chk_byte_eight_samples:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_q) |-> ($past(cnt_q) == `LAST_SAMPLE) && $past(run_tick))
    else $error("Byte completed without eight samples.");
  chk_msb_first_out:
  assert property (@(posedge aclk) disable iff (!aresetn)
    bus.load |=> bus.tx_bit == $past(bus.load_data[7]))
    else $error("First bit out is not the most significant.");
  chk_master_clock_toggle:
  assert property (@(posedge aclk) disable iff (!aresetn || bus.clear)
    (run_tick && bus.master && (edge_q <= `LAST_EDGE) && !bus.load) |=> sck_q != $past(sck_q))
    else $error("Master clock edge missing.");
endmodule

// >>> hw/spi_port.sv
// Serial port in SPI mode with an AXI4-Lite register slave.
// Assumes pins arrive unsynchronised and the timer pulse is on aclk.
`timescale 1ns/100ps
`include "spi_port_map.svh"
module spi_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  // System
  input wire logic sleep,
  input wire logic timer_two_pulse,
  output logic port_irq
);
  engine_if eng ();

  logic aw_free_q, w_free_q, ar_free_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] meta_q, sync_q;
  logic sck_prev_q;
  logic write_collision_q, ovf_q, en_q, ckp_q, smp_q, cke_q, bf_q, flag_q, irq_en_q;
  logic [3:0] mode_q;
  logic [3:0] pins_q;
  logic [7:0] buf_q;
  logic [5:0] div_q;
  logic sck_o_q, sck_oe_q, sdo_o_q, sdo_oe_q, ss_n_o_q, ss_n_oe_q, irq_q;
  logic is_master, is_slave, ss_ctrl, ss_level, mod_clear;
  logic wr_go, wr_lane, buf_wr, collide, rd_go, buf_rd;
  logic run_div, mtick, sedge;
  logic [5:0] half_m1;
  logic [31:0] rd_word;
  logic rd_hit;

  // ======================================================
  // Mode decode
  assign is_master = (mode_q == spi_port_pkg::MODE_MASTER_DIV4) || (mode_q == spi_port_pkg::MODE_MASTER_DIV16)
    || (mode_q == spi_port_pkg::MODE_MASTER_DIV64) || (mode_q == spi_port_pkg::MODE_MASTER_TIMER);
  assign is_slave = (mode_q == spi_port_pkg::MODE_SLAVE_SS) || (mode_q == spi_port_pkg::MODE_SLAVE_FREE);
  assign ss_ctrl = mode_q == spi_port_pkg::MODE_SLAVE_SS;
  // A select pin set as output reads back its own latch.
  assign ss_level = pins_q[`PIN_SS_DIR] ? sync_q[2] : pins_q[`PIN_SS_LATCH];
  assign mod_clear = !en_q || (ss_ctrl && ss_level);

  // ======================================================
  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= `SYNC_RESET;
      sync_q <= `SYNC_RESET;
      sck_prev_q <= 1'b0;
    end else begin
      meta_q <= {ss_n_i, sdi_i, sck_i};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[0];
    end
  end

  // ======================================================
  // Master bit clock
  always_comb begin
    unique case (mode_q)
      spi_port_pkg::MODE_MASTER_DIV16: half_m1 = `HALF_DIV16;
      spi_port_pkg::MODE_MASTER_DIV64: half_m1 = `HALF_DIV64;
      default: half_m1 = `HALF_DIV4;
    endcase
  end
  // Sleep only clears and holds the divider, so a master byte resumes where it stopped.
  assign run_div = is_master && eng.busy && !sleep && !mod_clear;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_div || (div_q == half_m1)) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end
  assign mtick = run_div && ((mode_q == spi_port_pkg::MODE_MASTER_TIMER) ? timer_two_pulse : (div_q == half_m1));
  assign sedge = is_slave && pins_q[`PIN_SCK_DIR] && (sync_q[0] != sck_prev_q);

  // ======================================================
  // Engine hookup
  assign eng.clear = mod_clear;
  assign eng.load = buf_wr && !eng.busy && !mod_clear && (is_master || is_slave);
  assign eng.load_data = wdata_q;
  assign eng.tick = !mod_clear && (is_master ? mtick : sedge);
  assign eng.master = is_master;
  assign eng.cke = cke_q;
  assign eng.sample_phase = is_master && smp_q;
  assign eng.clock_polarity = ckp_q;
  assign eng.serial_in = sync_q[1];

  serial_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(eng)
  );

  // ======================================================
  // AXI4-Lite slave
  assign wr_go = !aw_free_q && !w_free_q && !bvalid_q;
  assign wr_lane = wr_go && wlane_q;
  assign buf_wr = wr_lane && (awaddr_q == `OFS_BUFFER);
  assign collide = buf_wr && eng.busy;
  assign rd_go = arvalid && ar_free_q;
  assign buf_rd = rd_go && (araddr == `OFS_BUFFER);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free_q <= 1'b1;
      w_free_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && aw_free_q) begin
        aw_free_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && w_free_q) begin
        w_free_q <= 1'b0;
        wdata_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= ((awaddr_q == `OFS_BUFFER) || (awaddr_q == `OFS_CONTROL) || (awaddr_q == `OFS_STATUS)
          || (awaddr_q == `OFS_IRQ) || (awaddr_q == `OFS_PINS)) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_free_q <= 1'b1;
        w_free_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    unique case (araddr)
      `OFS_BUFFER: rd_word[7:0] = buf_q;
      `OFS_CONTROL: rd_word[7:0] = {write_collision_q, ovf_q, en_q, ckp_q, mode_q};
      `OFS_STATUS: rd_word[7:0] = {smp_q, cke_q, 5'h00, bf_q};
      `OFS_IRQ: rd_word[1:0] = {irq_en_q, flag_q};
      `OFS_PINS: rd_word[3:0] = pins_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_free_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (rd_go) begin
      ar_free_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      ar_free_q <= 1'b1;
    end
  end

  // ======================================================
  // Control and status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      ckp_q <= 1'b0;
      mode_q <= `MODE_RESET;
      smp_q <= 1'b0;
      cke_q <= 1'b0;
      irq_en_q <= 1'b0;
      pins_q <= `PINS_RESET;
    end else if (wr_lane) begin
      if (awaddr_q == `OFS_CONTROL) begin
        en_q <= wdata_q[`CTL_EN];
        ckp_q <= wdata_q[`CTL_CKP];
        mode_q <= wdata_q[3:0];
      end
      if (awaddr_q == `OFS_STATUS) begin
        smp_q <= wdata_q[`STA_SMP];
        cke_q <= wdata_q[`STA_CKE];
      end
      if (awaddr_q == `OFS_IRQ) begin
        irq_en_q <= wdata_q[`IRQ_EN];
      end
      if (awaddr_q == `OFS_PINS) begin
        pins_q <= wdata_q[3:0];
      end
    end
  end

  // Sticky flags clear on a written zero; a new event in that cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_collision_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (collide) begin
        write_collision_q <= 1'b1;
      end else if (wr_lane && (awaddr_q == `OFS_CONTROL) && !wdata_q[`CTL_WRITE_COLLISION]) begin
        write_collision_q <= 1'b0;
      end
      if (eng.done && is_slave && bf_q) begin
        ovf_q <= 1'b1;
      end else if (wr_lane && (awaddr_q == `OFS_CONTROL) && !wdata_q[`CTL_OVF]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (eng.done) begin
      flag_q <= 1'b1;
    end else if (wr_lane && (awaddr_q == `OFS_IRQ) && !wdata_q[`IRQ_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // ======================================================
  // Receive buffer
  // A slave byte that finds the buffer full is dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_q <= 8'h00;
      bf_q <= 1'b0;
    end else begin
      if (eng.done && !(is_slave && bf_q)) begin
        buf_q <= eng.rx_data;
      end else if (buf_wr && !eng.busy) begin
        buf_q <= wdata_q;
      end
      if (eng.done) begin
        bf_q <= 1'b1;
      end else if (buf_rd) begin
        bf_q <= 1'b0;
      end
    end
  end

  // ======================================================
  // Pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_o_q <= 1'b0;
      sck_oe_q <= 1'b0;
      sdo_o_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      ss_n_o_q <= 1'b1;
      ss_n_oe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sck_o_q <= eng.sck_lvl;
      sck_oe_q <= en_q && is_master && !pins_q[`PIN_SCK_DIR];
      sdo_o_q <= eng.tx_bit;
      sdo_oe_q <= en_q && !pins_q[`PIN_SDO_DIR] && (is_master || (is_slave && !(ss_ctrl && ss_level)));
      ss_n_o_q <= pins_q[`PIN_SS_LATCH];
      ss_n_oe_q <= !pins_q[`PIN_SS_DIR];
      irq_q <= flag_q && irq_en_q;
    end
  end

  assign awready = aw_free_q;
  assign wready = w_free_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ar_free_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign sck_o = sck_o_q;
  assign sck_oe = sck_oe_q;
  assign sdo_o = sdo_o_q;
  assign sdo_oe = sdo_oe_q;
  assign ss_n_o = ss_n_o_q;
  assign ss_n_oe = ss_n_oe_q;
  assign port_irq = irq_q;

  // ======================================================
  // Checks
  chk_write_collision_on_busy:
  assert property (@(posedge aclk) disable iff (!aresetn)
    collide |=> write_collision_q && $stable(buf_q))
    else $error("Collision not flagged or buffer changed.");
  chk_bf_on_byte:
  assert property (@(posedge aclk) disable iff (!aresetn)
    eng.done |=> bf_q && flag_q)
    else $error("Byte end did not set full and flag.");
  chk_bf_read_clear:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (buf_rd && !eng.done) |=> !bf_q)
    else $error("Buffer read did not clear full.");
  chk_sdo_float_deselect:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (ss_ctrl && ss_level) |=> !sdo_oe && !eng.busy)
    else $error("Serial out driven while deselected.");
  chk_sleep_freeze:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep && is_master && en_q && eng.busy) |-> !eng.tick ##1 $stable(eng.sck_lvl))
    else $error("Master clock moved during sleep.");
  chk_irq_gated:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 port_irq == ($past(flag_q) && $past(irq_en_q)))
    else $error("Interrupt request not gated by enable.");
endmodule

// >>> verification/spi_slave_model.sv
// Behavioural SPI slave that answers the port while the port is master.
// Assumes select and polarity change only between frames.
`timescale 1ns/100ps
module spi_slave_model (
  // Pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic cpol,
  output logic miso,
  // Bytes
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  // ======================================================
  // Shifting
  logic [7:0] sh = 8'h00;
  initial miso = 1'b1;
  initial rx_byte = 8'h00;
  always @(negedge cs_n) begin
    sh = tx_byte;
    miso = sh[7];
  end
  always @(sck) begin
    if (!cs_n) begin
      if (sck != cpol) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else begin
        sh = {sh[6:0], 1'b0};
        miso = sh[7];
      end
    end
  end
  // A released line shows the inverse of its last bit.
  always @(posedge cs_n) miso = ~miso;
endmodule

// >>> verification/sync_serial_spi_mode_tb.sv
// Self-checking bench for the serial port: register tasks and byte transfers.
// Assumes the port and a slave model face each other over the serial pins.
`timescale 1ns/100ps
`include "spi_port_map.svh"
module sync_serial_spi_mode_tb;
  // ======================================================
  // Signals
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, s_tx = 8'h00, s_rx;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sdo_o, sdo_oe, ss_n_o, ss_n_oe, port_irq;
  logic sck_i = 0, ss_n_i = 1, sleep = 0, tpulse = 0, sel_n = 1, cpol = 0, miso;
  logic [5:0] tcnt = 6'h00;
  int num_errors = 0, total_checks = 0;
  int hv[4] = '{2, 8, 32, 5};
  logic [7:0] ofs[4] = '{`OFS_CONTROL, `OFS_STATUS, `OFS_IRQ, `OFS_PINS};
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    tcnt <= (tcnt == 6'h04) ? 6'h00 : tcnt + 6'h01;
    tpulse <= (tcnt == 6'h04);
  end
  spi_port dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .sck_i, .sck_o, .sck_oe, .sdi_i(miso), .sdo_o, .sdo_oe, .ss_n_i, .ss_n_o, .ss_n_oe,
    .sleep, .timer_two_pulse(tpulse), .port_irq);
  spi_slave_model slave (.sck(sck_o), .mosi(sdo_o), .cs_n(sel_n), .cpol(cpol), .miso(miso),
    .tx_byte(s_tx), .rx_byte(s_rx));
  // ======================================================
  // Tasks
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task edge_n(inout int n);
    @(posedge aclk);
    n++;
    if (n > 400) begin
      num_errors++;
      $display("[FAIL] wait expected done seen timeout");
      print_verdict();
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ad, wd;
    n = 0;
    ad = 0;
    wd = 0;
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; wstrb <= 4'hF; bready <= 1;
    while (!(ad && wd)) begin
      edge_n(n);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) edge_n(n);
    rsp = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task axr(input logic [7:0] a);
    int n;
    n = 0;
    arvalid <= 1; araddr <= a; rready <= 1;
    do edge_n(n); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) edge_n(n);
    rd = rdata;
    rsp = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task wait_full;
    int n;
    n = 0;
    do begin
      axr(`OFS_STATUS);
      n++;
      if (n > 300) begin
        n = 400;
        edge_n(n);
      end
    end while (rd[0] !== 1'b1);
  endtask
  task xfer(input logic [7:0] tx, input logic [7:0] rx, input int half, input logic slp);
    int n, g;
    logic s;
    n = 0;
    g = 0;
    s_tx = rx;
    sel_n <= 0;
    @(posedge aclk);
    axw(`OFS_BUFFER, {24'h0, tx});
    s = sck_o;
    while (sck_o === s) edge_n(n);
    s = sck_o;
    while (sck_o === s) begin
      edge_n(n);
      g++;
    end
    chk("half period", g, half);
    if (slp) begin
      sleep <= 1;
      repeat (3) @(posedge aclk);
      s = sck_o;
      repeat (30) @(posedge aclk);
      chk("frozen clock", sck_o, s);
      sleep <= 0;
    end
    wait_full();
    axr(`OFS_BUFFER);
    chk("rx byte", rd, rx);
    chk("slave byte", s_rx, tx);
    axr(`OFS_STATUS);
    chk("full cleared", rd[0], 0);
    sel_n <= 1;
  endtask
  // ======================================================
  // Sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      axr(ofs[i]);
      chk("reset value", rd, (i == 3) ? {28'h0, `PINS_RESET} : 32'h0);
    end
    axr(8'h20);
    chk("unmapped resp", rsp, `RESP_SLVERR);
    $display("test reset done");
    axw(`OFS_PINS, 32'h0C);
    chk("write resp", rsp, `RESP_OKAY);
    axw(`OFS_STATUS, 32'h40);
    for (int i = 0; i < 4; i++) begin
      axw(`OFS_CONTROL, 32'h0);
      cpol = (i == 2);
      axw(`OFS_CONTROL, 32'h20 | ((i == 2) ? 32'h10 : 32'h0) | i);
      repeat (4) @(posedge aclk);
      chk("idle clock", sck_o, cpol);
      chk("clock drive", sck_oe, 1);
      xfer(8'hA5 - 8'(i), 8'h3C + 8'(i), hv[i], i == 1);
      $display("test master mode %0d done", i);
    end
    axr(`OFS_IRQ);
    chk("irq flag", rd, 32'h1);
    chk("irq masked", port_irq, 0);
    axw(`OFS_IRQ, 32'h3);
    repeat (3) @(posedge aclk);
    chk("irq raised", port_irq, 1);
    axw(`OFS_IRQ, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq cleared", port_irq, 0);
    $display("test irq done");
    axw(`OFS_BUFFER, 32'h11);
    axw(`OFS_BUFFER, 32'h22);
    wait_full();
    axr(`OFS_CONTROL);
    chk("collision", rd, 32'hA3);
    axr(`OFS_BUFFER);
    $display("test collision done");
    axw(`OFS_CONTROL, 32'h0);
    axw(`OFS_PINS, 32'h0E);
    axw(`OFS_CONTROL, 32'h24);
    ss_n_i <= 0;
    repeat (6) @(posedge aclk);
    chk("select drive", sdo_oe, 1);
    chk("slave clock", sck_oe, 0);
    ss_n_i <= 1;
    repeat (5) @(posedge aclk);
    chk("select float", sdo_oe, 0);
    chk("select input", ss_n_oe, 0);
    $display("test select done");
    axw(`OFS_CONTROL, 32'h0);
    axw(`OFS_PINS, 32'h0D);
    axw(`OFS_CONTROL, 32'h20);
    xfer(8'h00, 8'h5A, 2, 0);
    chk("monitor float", sdo_oe, 0);
    $display("test monitor done");
    print_verdict();
  end
endmodule
